// >>> test/tsf_flags_properties.sv
// checker for the status flag block
// sees only the ports of tsf_flags, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tsf_flags_properties
  import tsf_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [4:0] mode_req,
  input wire logic       bus_dom,
  input wire logic       txd_dom,
  input wire logic       local_wake,
  input wire logic       vbat_recover,
  input wire logic       supply_undervoltage_flag,
  input wire logic       io_supply,
  input wire logic       bus_short,
  input wire logic       local_fault,
  input wire logic [4:0] mode,
  input wire logic       fault_status_out,
  input wire logic       rxd_out,
  input wire logic       tx_enable
);
  // ****
  // helpers
  // ****
  logic lp;
  logic nrm;
  logic short_seen;
  assign lp  = mode == TSF_SLEEP || mode == TSF_STANDBY || mode == TSF_GOSLEEP;
  assign nrm = mode == TSF_NORMAL;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      short_seen <= 1'b0;
    else
      short_seen <= nrm && (short_seen || bus_short);
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_force;
    mode_req == TSF_NORMAL && !nrm && !local_fault;
  endsequence
  sequence s_quiet;
    (mode_req == 5'h00 && !local_fault) [*3];
  endsequence
  a_mode_take: assert property (
    $onehot(mode_req) && mode_req != TSF_SLEEP |=> mode == $past(mode_req))
    else $error("mode request not taken");
  a_mode_hold: assert property (
    mode_req == 5'h00 |=> mode == $past(mode))
    else $error("mode moved without request");
  a_sleep_refused: assert property (
    mode_req == TSF_SLEEP && lp && $past(lp) && !rxd_out && !supply_undervoltage_flag
    && !$past(supply_undervoltage_flag) |=> mode == $past(mode))
    else $error("sleep taken with wakeup pending");
  a_lowpow_mirror: assert property (
    lp && $past(lp) && $past(lp, 2) && io_supply && $past(io_supply)
    |-> fault_status_out == rxd_out)
    else $error("fault and rxd disagree in low power");
  a_normal_rxd: assert property (
    nrm && $past(nrm) |-> rxd_out == !$past(bus_dom))
    else $error("rxd not following bus in normal");
  a_fault_gates_tx: assert property (
    local_fault |-> ##[1:2] !tx_enable)
    else $error("transmitter left on after local fault");
  a_normal_reenable: assert property (
    s_force ##1 s_quiet |-> tx_enable)
    else $error("transmitter not back after normal entry");
  a_no_false_bus: assert property (
    nrm && $past(nrm) && $past(nrm, 2) && $fell(fault_status_out) |-> short_seen)
    else $error("bus failure shown without short");
endmodule // tsf_flags_properties
bind tsf_flags tsf_flags_properties tsf_flags_properties_i (
  .clk_sys(clk_sys), .rstn(rstn), .mode_req(mode_req), .bus_dom(bus_dom),
  .txd_dom(txd_dom), .local_wake(local_wake), .vbat_recover(vbat_recover),
  .supply_undervoltage_flag(supply_undervoltage_flag), .io_supply(io_supply),
  .bus_short(bus_short), .local_fault(local_fault), .mode(mode),
  .fault_status_out(fault_status_out), .rxd_out(rxd_out), .tx_enable(tx_enable)
);
`default_nettype wire

// >>> test/tsf_flags_test.sv
// self-checking bench of the status flag block
// assumes tsf_host as controller and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tsf_flags_test
  import tsf_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [4:0] mode_req;
  logic       bus_dom = 1'b0;
  logic       txd_dom = 1'b0;
  logic       local_wake = 1'b0;
  logic       vbat_recover = 1'b0;
  logic       supply_undervoltage_flag = 1'b0;
  logic       io_supply = 1'b1;
  logic       bus_short = 1'b0;
  logic       local_fault = 1'b0;
  logic [4:0] mode;
  logic       fault_status_out;
  logic       rxd_out;
  logic       tx_enable;
  int         n_errors = 0;
  int         compares = 0;
  int         cyc = 0;
  always #5 clk_sys = ~clk_sys;
  tsf_host tsf_host_i (.clk_sys(clk_sys), .fault_status_out(fault_status_out),
    .mode_req(mode_req));
  tsf_flags tsf_flags_i (
    .clk_sys(clk_sys), .rstn(rstn), .mode_req(mode_req), .bus_dom(bus_dom),
    .txd_dom(txd_dom), .local_wake(local_wake), .vbat_recover(vbat_recover),
    .supply_undervoltage_flag(supply_undervoltage_flag), .io_supply(io_supply),
    .bus_short(bus_short), .local_fault(local_fault), .mode(mode),
    .fault_status_out(fault_status_out), .rxd_out(rxd_out), .tx_enable(tx_enable)
  );
  // ****
  // tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic md(input logic [4:0] m, input logic [4:0] e);
    tsf_host_i.set_mode(m);
    `CK("mode", e, mode)
  endtask
  task automatic fs(input logic e);
    logic got;
    tsf_host_i.get(got);
    `CK("fault", e, got)
  endtask
  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    tick(n);
    s = 1'b0;
    tick(10);
  endtask
  task automatic wk;
    local_wake = ~local_wake;
    tick(10);
  endtask
  // bus wake pattern, each phase above the minimum
  task automatic bw;
    pulse(bus_dom, 550);
    tick(540);
    pulse(bus_dom, 550);
  endtask
  // each dominant phase exactly the minimum
  task automatic tx(input int n);
    repeat (n)
    begin
      pulse(txd_dom, 400);
      tick(30);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    tick(20);
    rstn = 1'b1;
    tick(2);
    `CK("mode", TSF_STANDBY, mode)
    fs(1'b0);
    `CK("rxd", 1'b0, rxd_out)
    md(TSF_SLEEP, TSF_STANDBY);
    md(5'h0a, TSF_STANDBY);
    md(TSF_NORMAL, TSF_NORMAL);
    fs(1'b0);
    wk;
    bw;
    md(TSF_STANDBY, TSF_STANDBY);
    fs(1'b1);
    md(TSF_SLEEP, TSF_SLEEP);
    wk;
    fs(1'b0);
    `CK("rxd", 1'b0, rxd_out)
    md(TSF_LISTEN, TSF_LISTEN);
    fs(1'b1);
    pulse(vbat_recover, 1);
    fs(1'b0);
    md(TSF_NORMAL, TSF_NORMAL);
    fs(1'b0);
    tx(3);
    fs(1'b0);
    pulse(txd_dom, 399);
    fs(1'b0);
    tx(1);
    fs(1'b1);
    md(TSF_STANDBY, TSF_STANDBY);
    md(TSF_NORMAL, TSF_NORMAL);
    fs(1'b1);
    bus_short = 1'b1;
    tx(4);
    fs(1'b0);
    `CK("tx_en", 1'b1, tx_enable)
    bus_short = 1'b0;
    pulse(local_fault, 5);
    `CK("tx_en", 1'b0, tx_enable)
    md(TSF_LISTEN, TSF_LISTEN);
    fs(1'b0);
    pulse(bus_dom, 5);
    fs(1'b1);
    pulse(local_fault, 5);
    md(TSF_NORMAL, TSF_NORMAL);
    `CK("tx_en", 1'b1, tx_enable)
    md(TSF_STANDBY, TSF_STANDBY);
    bw;
    fs(1'b0);
    md(TSF_NORMAL, TSF_NORMAL);
    fs(1'b1);
    md(TSF_GOSLEEP, TSF_GOSLEEP);
    wk;
    fs(1'b0);
    io_supply = 1'b0;
    fs(1'b1);
    io_supply = 1'b1;
    pulse(supply_undervoltage_flag, 5);
    fs(1'b1);
    tally_and_finish;
  end
endmodule // tsf_flags_test
`default_nettype wire

// >>> test/tsf_host.sv
// host controller model: commands modes, reads the fault output
// assumes the bench clock, inputs changed at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tsf_host
  import tsf_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       fault_status_out,
  output var  logic [4:0] mode_req
);
  localparam int unsigned SETTLE_CYC = 1000;
  initial mode_req = 5'h00;
  task automatic set_mode(input logic [4:0] m);
    @(negedge clk_sys);
    mode_req = m;
    @(negedge clk_sys);
    mode_req = 5'h00;
    repeat (SETTLE_CYC) @(negedge clk_sys);
  endtask
  // caller keeps the transmitter quiet while reading
  task automatic get(output logic v);
    @(negedge clk_sys);
    v = fault_status_out;
  endtask
endmodule // tsf_host
`default_nettype wire

// >>> verilog/tsf_bus_wake.sv
// bus wakeup pattern detector: dominant, recessive, dominant, each
// at least the minimum phase, whole pattern inside the window
// assumes bus_dom synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module tsf_bus_wake
  import tsf_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic bus_dom,
  output var  logic wake_pulse
);

  tsf_wk_t           state;
  logic [CNT_W-1:0]  phase_cnt;
  logic [CNT_W-1:0]  win_cnt;
  logic              phase_ok;
  logic              win_over;

  assign phase_ok = (phase_cnt >= CNT_W'(WAKE_PHASE_CYC - 1));
  assign win_over = (win_cnt >= CNT_W'(WAKE_WINDOW_CYC - 1));

  // ****************************************
  // pattern sequencer
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= TSF_WK_IDLE;
      phase_cnt  <= '0;
      win_cnt    <= '0;
      wake_pulse <= 1'b0;
    end
    else
    begin
      wake_pulse <= 1'b0;
      phase_cnt  <= (phase_cnt == '1) ? phase_cnt : phase_cnt + 1'b1;
      win_cnt    <= win_cnt + 1'b1;
      unique case (state)
        TSF_WK_IDLE:
        begin
          win_cnt   <= '0;
          phase_cnt <= '0;
          if (bus_dom)
            state <= TSF_WK_DOM1;
        end
        TSF_WK_DOM1:
        begin
          if (!bus_dom)
          begin
            phase_cnt <= '0;
            state     <= phase_ok ? TSF_WK_REC : TSF_WK_IDLE;
          end
        end
        TSF_WK_REC:
        begin
          if (win_over)
            state <= TSF_WK_IDLE;
          else if (bus_dom)
          begin
            phase_cnt <= '0;
            state     <= phase_ok ? TSF_WK_DOM2 : TSF_WK_DOM1;
          end
        end
        TSF_WK_DOM2:
        begin
          if (win_over)
            state <= TSF_WK_IDLE;
          else if (!bus_dom)
            state <= TSF_WK_IDLE;
          else if (phase_ok)
          begin
            wake_pulse <= 1'b1;
            state      <= TSF_WK_IDLE;
          end
        end
      endcase
    end
  end

endmodule // tsf_bus_wake
`default_nettype wire

// >>> verilog/tsf_flags.sv
// status flag keeper and fault status multiplexer of the transceiver
// assumes all inputs synchronous to clk_sys; mode_req is one-hot
//
// Behaviour
// - five flags, one shown by mode history
// - wakeup sets flag only in low-power modes
// - wakeups ignored in normal and listen-only
// - low-power modes show wakeup flag, low active, while io_supply is high
// - wakeup flag cleared by normal or undervoltage
// - no sleep entry while wakeup flag set
// - wakeup flag mirrored on receive pin in low-power modes
// - power-on also sets wakeup and source flags
// - battery recovery sets power-on, shown listen-only
// - power-on flag cleared entering normal
// - normal first shows wakeup source flag
// - source flag goes high leaving normal
// - four long dominant transmits select bus flag
// - bus flag resets leaving normal, recount needed
// - bus failure only reported, no action
// - listen-only from normal shows local failure
// - local failure disables transmitter
// - local failure cleared by normal or rx
// - bus flag low only on real short
// - bus wakeup needs dom-rec-dom pattern
`timescale 1ns/1ps
`default_nettype none
module tsf_flags
  import tsf_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [4:0] mode_req,
  input  wire logic       bus_dom,
  input  wire logic       txd_dom,
  input  wire logic       local_wake,
  input  wire logic       vbat_recover,
  input  wire logic       supply_undervoltage_flag,
  input  wire logic       io_supply,
  input  wire logic       bus_short,
  input  wire logic       local_fault,
  output logic [4:0]      mode,
  output logic            fault_status_out,
  output logic            rxd_out,
  output logic            tx_enable
);

  logic                  wake_flag;
  logic                  power_on_flag;
  logic                  src_flag;
  logic                  bus_fail_flag;
  logic                  local_fail_flag;
  tsf_mode_t             cur_mode;
  tsf_mode_t             prev_mode;
  tsf_mode_t             next_mode;
  logic                  mode_change;
  logic                  enter_normal;
  logic                  leave_normal;
  logic                  low_power;
  logic                  bus_wake;
  logic                  wake_event;
  logic                  local_wake_q;
  logic                  local_edge;
  logic                  txd_q;
  logic                  tx_rise;
  logic                  tx_armed;
  logic                  diag_reset;
  logic [CNT_W-1:0]      dom_cnt;
  logic                  dom_counted;
  logic [EDGE_CNT_W-1:0] tx_edges;
  logic                  rx_recover;
  tsf_sel_t              sel;
  logic                  sel_value;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_low_power(input tsf_mode_t m);
    is_low_power = (m == TSF_SLEEP) || (m == TSF_STANDBY) || (m == TSF_GOSLEEP);
  endfunction

  function automatic logic is_dom_long(input logic [CNT_W-1:0] c);
    is_dom_long = (c == CNT_W'(TX_DOM_CYC - 1));
  endfunction

  // ****************************************
  // mode control
  // ****************************************
  always_comb
  begin
    next_mode = cur_mode;
    // a refused sleep keeps mode and history
    unique case (mode_req)
      5'h01:   next_mode = wake_flag ? cur_mode : TSF_SLEEP;
      5'h02:   next_mode = TSF_STANDBY;
      5'h04:   next_mode = TSF_GOSLEEP;
      5'h08:   next_mode = TSF_NORMAL;
      5'h10:   next_mode = TSF_LISTEN;
      default: next_mode = cur_mode;
    endcase
  end

  assign mode_change  = (next_mode != cur_mode);
  assign enter_normal = mode_change && (next_mode == TSF_NORMAL);
  assign leave_normal = mode_change && (cur_mode == TSF_NORMAL);
  assign low_power    = is_low_power(cur_mode);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_mode  <= TSF_STANDBY;
      prev_mode <= TSF_STANDBY;
    end
    else if (mode_change)
    begin
      cur_mode  <= next_mode;
      prev_mode <= cur_mode;
    end
  end

  assign mode = cur_mode;

  // ****************************************
  // wakeup sources
  // ****************************************
  tsf_bus_wake u_bus_wake
  (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .bus_dom    (bus_dom),
    .wake_pulse (bus_wake)
  );

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      local_wake_q <= 1'b0;
    else
      local_wake_q <= local_wake;
  end

  // either edge of the wake input counts
  assign local_edge = local_wake ^ local_wake_q;
  assign wake_event = (bus_wake || local_edge) && low_power;

  // ****************************************
  // wakeup flag
  // ****************************************
  // a set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wake_flag <= 1'b1;
    else if (vbat_recover)
      wake_flag <= 1'b1;
    else if (wake_event)
      wake_flag <= 1'b1;
    else if (enter_normal || supply_undervoltage_flag)
      wake_flag <= 1'b0;
  end

  // ****************************************
  // power-on flag
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      power_on_flag <= 1'b1;
    else if (vbat_recover)
      power_on_flag <= 1'b1;
    else if (enter_normal)
      power_on_flag <= 1'b0;
  end

  // ****************************************
  // wakeup source flag, low for local wake
  // ****************************************
  // a local wake wins a tie with a bus wake
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      src_flag <= 1'b0;
    else if (vbat_recover)
      src_flag <= 1'b0;
    else if (local_edge && low_power)
      src_flag <= 1'b0;
    else if (bus_wake && low_power)
      src_flag <= 1'b1;
    else if (leave_normal)
      src_flag <= 1'b1;
  end

  // ****************************************
  // transmitted dominant phase counter
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      txd_q <= 1'b0;
    else
      txd_q <= txd_dom;
  end

  // only a recessive-to-dominant edge opens a phase
  assign tx_rise    = txd_dom && !txd_q;
  assign diag_reset = (cur_mode != TSF_NORMAL) || leave_normal;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tx_armed <= 1'b0;
    else if (!txd_dom || !tx_enable)
      tx_armed <= 1'b0;
    else if (tx_rise)
      tx_armed <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dom_cnt     <= '0;
      dom_counted <= 1'b0;
    end
    else if (!txd_dom || !tx_enable)
    begin
      dom_cnt     <= '0;
      dom_counted <= 1'b0;
    end
    else
    begin
      if (dom_cnt != '1)
        dom_cnt <= dom_cnt + 1'b1;
      if (tx_armed && is_dom_long(dom_cnt))
        dom_counted <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tx_edges <= '0;
    else if (diag_reset)
      tx_edges <= '0;
    else if (txd_dom && tx_enable && tx_armed && !dom_counted
             && is_dom_long(dom_cnt)
             && tx_edges != TX_EDGES_NEEDED)
      tx_edges <= tx_edges + 1'b1;
  end

  // ****************************************
  // bus failure flag, low only on short
  // ****************************************
  // taken during each long phase, the last one wins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bus_fail_flag <= 1'b1;
    else if (diag_reset)
      bus_fail_flag <= 1'b1;
    else if (dom_counted)
      bus_fail_flag <= !bus_short;
  end

  // ****************************************
  // local failure flag and transmitter gate
  // ****************************************
  assign rx_recover = bus_dom && !txd_dom;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      local_fail_flag <= 1'b1;
    else if (local_fault)
      local_fail_flag <= 1'b0;
    else if (enter_normal || rx_recover)
      local_fail_flag <= 1'b1;
  end

  // stays off after a fault until a recovery event
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tx_enable <= 1'b0;
    else
      tx_enable <= local_fail_flag && !local_fault
                   && (cur_mode == TSF_NORMAL);
  end

  // ****************************************
  // flag selection
  // ****************************************
  always_comb
  begin
    sel = TSF_SHOW_WAKE;
    unique case (cur_mode)
      TSF_SLEEP, TSF_STANDBY, TSF_GOSLEEP:
        sel = TSF_SHOW_WAKE;
      TSF_NORMAL:
        sel = (tx_edges == TX_EDGES_NEEDED) ? TSF_SHOW_BUS : TSF_SHOW_SRC;
      // history picks the flag shown in listen-only
      TSF_LISTEN:
        sel = (prev_mode == TSF_NORMAL) ? TSF_SHOW_LOCAL : TSF_SHOW_POWER_ON_FLAG;
    endcase
  end

  always_comb
  begin
    sel_value = 1'b1;
    unique case (sel)
      TSF_SHOW_WAKE:  sel_value = !(wake_flag && io_supply);
      TSF_SHOW_POWER_ON_FLAG:  sel_value = !power_on_flag;
      TSF_SHOW_SRC:   sel_value = src_flag;
      TSF_SHOW_BUS:   sel_value = bus_fail_flag;
      TSF_SHOW_LOCAL: sel_value = local_fail_flag;
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fault_status_out <= 1'b1;
    else
      fault_status_out <= sel_value;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rxd_out <= 1'b1;
    else if (low_power)
      rxd_out <= !wake_flag;
    else
      rxd_out <= !bus_dom;
  end

endmodule // tsf_flags
`default_nettype wire

// >>> verilog/tsf_pkg.sv
// package for the transceiver status flag logic
// assumes a single 100 MHz system clock
package tsf_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned TX_DOM_MIN_NS   = 4000;
  localparam int unsigned WAKE_PHASE_NS   = 5000;
  localparam int unsigned WAKE_WINDOW_US  = 500;
  localparam int unsigned TX_DOM_CYC      = (TX_DOM_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_PHASE_CYC  = (WAKE_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_WINDOW_CYC = WAKE_WINDOW_US * CLK_MHZ;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned EDGE_CNT_W      = 3;
  localparam logic [2:0]  TX_EDGES_NEEDED = 3'h4;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [4:0] {
    TSF_SLEEP   = 5'h01,
    TSF_STANDBY = 5'h02,
    TSF_GOSLEEP = 5'h04,
    TSF_NORMAL  = 5'h08,
    TSF_LISTEN  = 5'h10
  } tsf_mode_t;

  // ****************************************
  // flag shown on the fault output
  // ****************************************
  typedef enum logic [4:0] {
    TSF_SHOW_WAKE   = 5'h01,
    TSF_SHOW_POWER_ON_FLAG   = 5'h02,
    TSF_SHOW_SRC    = 5'h04,
    TSF_SHOW_BUS    = 5'h08,
    TSF_SHOW_LOCAL  = 5'h10
  } tsf_sel_t;

  // ****************************************
  // bus wakeup pattern states
  // ****************************************
  typedef enum logic [3:0] {
    TSF_WK_IDLE = 4'h1,
    TSF_WK_DOM1 = 4'h2,
    TSF_WK_REC  = 4'h4,
    TSF_WK_DOM2 = 4'h8
  } tsf_wk_t;

endpackage
